// ### rxsc_params.svh
// constants of the receive status and collision register block
`ifndef RXSC_PARAMS_SVH
`define RXSC_PARAMS_SVH
`define RXSC_ADDR_STATUS 8'h0b
`define RXSC_ADDR_BITCTRL 8'h0c
`define RXSC_ADDR_COLL 8'h0d
`define RXSC_ADDR_IRQSTAT 8'h0e
`define RXSC_ADDR_IRQMASK 8'h0f
`define RXSC_ADDR_ERRFLAGS 8'h10
`define RXSC_BIT_CIPHER 5
`define RXSC_BIT_KEEP 7
`define RXSC_ALIGN_HI 6
`define RXSC_ALIGN_LO 4
`define RXSC_BIT_COLLINTEG 3
`define RXSC_STATE_UNUSED 3'h4
`define RXSC_POS_LAST 3'h7
`define RXSC_POS_STEP 3'h1
`define RXSC_COUNT_MAX 7'h7f
`define RXSC_MAX_COLL_COUNT 7'h3f
`define RXSC_ZERO2 2'h0
`define RXSC_MAX_COLL_POS 7'h3f
`define RXSC_ZERO8 8'h00
`define RXSC_ZERO3 3'h0
`define RXSC_ZERO7 7'h00
`define RXSC_ONE7 7'h01
`define RXSC_IRQ_W 3
`define RXSC_IRQ_COLL 0
`define RXSC_IRQ_INTEG 1
`define RXSC_IRQ_RXEND 2
`endif

// ### rxsc_pkg.sv
// types of the receive status and collision register block
package rxsc_pkg;
  typedef enum logic [2:0] {
    RXSC_IDLE = 3'h0,
    RXSC_TX_WAIT = 3'h1,
    RXSC_TX = 3'h3,
    RXSC_RX_WAIT = 3'h5,
    RXSC_WAIT_DATA = 3'h6,
    RXSC_RX = 3'h7
  } rxsc_link_state_t;

  typedef struct packed {
    logic keepBits;
    logic [2:0] firstBitPos;
    logic collIntegErr;
    logic [2:0] lastBits;
  } rxsc_bitctrl_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } rxsc_wb_req_t;
endpackage : rxsc_pkg

// ### rxsc_regs.sv
// receive status, bit framing and collision registers with wishbone slave
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`include "rxsc_params.svh"

module rxsc_regs (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire rxsc_pkg::rxsc_link_state_t linkState,
  input wire logic authOk,
  input wire logic rxStart,
  input wire logic rxEnd,
  input wire logic rxBitValid,
  input wire logic rxBitData,
  input wire logic rxBitColl,
  output logic cipherActive,
  output logic byteOriented,
  output logic storeValid,
  output logic [7:0] storeByte,
  output logic collisionDetected,
  output logic integrityError,
  output logic irq
);

  // ********************************
  // bus decode
  // ********************************
  rxsc_pkg::rxsc_wb_req_t req;
  logic access;
  logic wrEn;
  logic cipher_reg;
  rxsc_pkg::rxsc_bitctrl_t ctrl_reg;
  logic collValid_reg;
  logic [6:0] collision_position_reg;
  logic collSeen_reg;
  logic [6:0] bitCount_reg;
  logic [2:0] bitPos_reg;
  logic [7:0] shift_reg;
  logic [2:0] irqStat_reg;
  logic [2:0] irqMask_reg;
  logic collision_detected_reg;
  logic integ_reg;
  logic ack_reg;
  logic [31:0] rdata_next;
  logic [7:0] statusByte;
  logic [2:0] irqSet;
  logic bitOut;
  logic [6:0] absPos;
  logic selStatus;
  logic selCtrl;
  logic selColl;
  logic selIrqStat;
  logic selIrqMask;
  logic selErr;
  logic wrStatus;
  logic wrCtrl;
  logic wrIrqStat;
  logic wrIrqMask;
  logic collEvent;
  logic integSet;
  logic lastBit;
  logic partialEnd;
  logic inRange;
  logic lastBitsLoad;
  rxsc_pkg::rxsc_link_state_t stateCode;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction : hit

  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i,
    sel: wb_sel_i, dat: wb_dat_i};
  assign access = req.cyc && req.stb && !ack_reg;
  assign wrEn = access && req.we && req.sel[0];

  // ********************************
  // address decode
  // ********************************
  assign selStatus = hit(req.adr, `RXSC_ADDR_STATUS);
  assign selCtrl = hit(req.adr, `RXSC_ADDR_BITCTRL);
  assign selColl = hit(req.adr, `RXSC_ADDR_COLL);
  assign selIrqStat = hit(req.adr, `RXSC_ADDR_IRQSTAT);
  assign selIrqMask = hit(req.adr, `RXSC_ADDR_IRQMASK);
  assign selErr = hit(req.adr, `RXSC_ADDR_ERRFLAGS);
  assign wrStatus = wrEn && selStatus;
  assign wrCtrl = wrEn && selCtrl;
  assign wrIrqStat = wrEn && selIrqStat;
  assign wrIrqMask = wrEn && selIrqMask;

  // ********************************
  // bus answer
  // ********************************
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      ack_reg <= 1'b0;
    else
      ack_reg <= access;
  end

  // ********************************
  // link state
  // ********************************
  always_comb
  begin
    stateCode = linkState;
    if (linkState == `RXSC_STATE_UNUSED)
      stateCode = rxsc_pkg::RXSC_IDLE;
  end

  // ********************************
  // read data
  // ********************************
  assign statusByte = {`RXSC_ZERO2, cipher_reg, `RXSC_ZERO2, stateCode};
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    if (selStatus)
      rdata_next[7:0] = statusByte;
    else if (selCtrl)
      rdata_next[7:0] = ctrl_reg;
    else if (selColl)
      rdata_next[7:0] = {collValid_reg, collision_position_reg};
    else if (selIrqStat)
      rdata_next[2:0] = irqStat_reg;
    else if (selIrqMask)
      rdata_next[2:0] = irqMask_reg;
    else if (selErr)
      rdata_next[1:0] = {collision_detected_reg, integ_reg};
    else
      rdata_next = 32'h0000_0000;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      wb_dat_o <= 32'h0000_0000;
    else if (access && !req.we)
      wb_dat_o <= rdata_next;
  end
  assign wb_ack_o = ack_reg;

  // ********************************
  // cipher indicator
  // ********************************
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      cipher_reg <= 1'b0;
    else if (authOk)
      cipher_reg <= 1'b1;
    else if (wrStatus && !req.dat[`RXSC_BIT_CIPHER])
      cipher_reg <= 1'b0;
  end
  assign cipherActive = cipher_reg;

  // ********************************
  // bit framing control
  // ********************************
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      ctrl_reg <= '0;
    else
    begin
      if (wrCtrl)
      begin
        ctrl_reg.keepBits <= req.dat[`RXSC_BIT_KEEP];
        ctrl_reg.firstBitPos <= req.dat[`RXSC_ALIGN_HI:`RXSC_ALIGN_LO];
        ctrl_reg.collIntegErr <= req.dat[`RXSC_BIT_COLLINTEG];
      end
      if (rxStart)
        ctrl_reg.lastBits <= `RXSC_ZERO3;
      else if (lastBitsLoad)
        ctrl_reg.lastBits <= bitPos_reg;
    end
  end
  assign byteOriented = (ctrl_reg.firstBitPos == `RXSC_ZERO3);

  // ********************************
  // event decode
  // ********************************
  assign collEvent = rxBitValid && rxBitColl;
  assign integSet = collEvent && ctrl_reg.collIntegErr;
  assign lastBit = (bitPos_reg == `RXSC_POS_LAST);
  assign partialEnd = rxEnd && (bitPos_reg != `RXSC_ZERO3);
  assign inRange = (absPos <= `RXSC_MAX_COLL_POS) &&
    (bitCount_reg <= `RXSC_MAX_COLL_COUNT);
  assign lastBitsLoad = rxEnd && !byteOriented;

  // ********************************
  // bit assembly
  // ********************************
  assign bitOut = (collSeen_reg || rxBitColl) && !ctrl_reg.keepBits ?
    1'b0 : rxBitData;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      bitPos_reg <= `RXSC_ZERO3;
    else if (rxStart)
      bitPos_reg <= ctrl_reg.firstBitPos;
    else if (rxBitValid)
      bitPos_reg <= bitPos_reg + `RXSC_POS_STEP;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      shift_reg <= `RXSC_ZERO8;
    else if (rxStart)
      shift_reg <= `RXSC_ZERO8;
    else if (rxBitValid)
    begin
      if (lastBit)
        shift_reg <= `RXSC_ZERO8;
      else
        shift_reg[bitPos_reg] <= bitOut;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      storeValid <= 1'b0;
      storeByte <= `RXSC_ZERO8;
    end
    else if (rxBitValid && lastBit && !rxStart)
    begin
      storeValid <= 1'b1;
      storeByte <= {bitOut, shift_reg[6:0]};
    end
    else if (partialEnd && !rxStart && !rxBitValid)
    begin
      storeValid <= 1'b1;
      storeByte <= shift_reg;
    end
    else
      storeValid <= 1'b0;
  end

  // ********************************
  // collision tracking
  // ********************************
  assign absPos = bitCount_reg + {4'h0, ctrl_reg.firstBitPos};

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      bitCount_reg <= `RXSC_ZERO7;
    else if (rxStart)
      bitCount_reg <= `RXSC_ZERO7;
    else if (rxBitValid && bitCount_reg != `RXSC_COUNT_MAX)
      bitCount_reg <= bitCount_reg + `RXSC_ONE7;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      collSeen_reg <= 1'b0;
    else if (rxStart)
      collSeen_reg <= 1'b0;
    else if (collEvent)
      collSeen_reg <= 1'b1;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      collValid_reg <= 1'b0;
      collision_position_reg <= `RXSC_ZERO7;
    end
    else if (rxStart)
    begin
      collValid_reg <= 1'b0;
      collision_position_reg <= `RXSC_ZERO7;
    end
    else if (collEvent && !collSeen_reg && inRange)
    begin
      collValid_reg <= 1'b1;
      collision_position_reg <= absPos;
    end
  end

  // ********************************
  // error flags
  // ********************************
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      collision_detected_reg <= 1'b0;
    else if (collEvent)
      collision_detected_reg <= 1'b1;
    else if (rxStart)
      collision_detected_reg <= 1'b0;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      integ_reg <= 1'b0;
    else if (integSet)
      integ_reg <= 1'b1;
    else if (rxStart)
      integ_reg <= 1'b0;
  end
  assign collisionDetected = collision_detected_reg;
  assign integrityError = integ_reg;

  // ********************************
  // interrupts
  // ********************************
  assign irqSet = {rxEnd, integSet, collEvent};

  generate
    for (genvar i = 0; i < `RXSC_IRQ_W; i++)
    begin : g_irq_stat
      always_ff @(posedge ref_clk or negedge arst_n)
      begin
        if (!arst_n)
          irqStat_reg[i] <= 1'b0;
        else if (irqSet[i])
          irqStat_reg[i] <= 1'b1;
        else if (wrIrqStat && req.dat[i])
          irqStat_reg[i] <= 1'b0;
      end
    end
  endgenerate

  generate
    for (genvar j = 0; j < `RXSC_IRQ_W; j++)
    begin : g_irq_mask
      always_ff @(posedge ref_clk or negedge arst_n)
      begin
        if (!arst_n)
          irqMask_reg[j] <= 1'b0;
        else if (wrIrqMask)
          irqMask_reg[j] <= req.dat[j];
      end
    end
  endgenerate

  // ********************************
  // interrupt output
  // ********************************
  assign irq = |(irqStat_reg & irqMask_reg);

endmodule : rxsc_regs

// ### rxsc_checker.sv
// concurrent checks on the ports of the receive status register block
`timescale 1ns/100ps
module rxsc_checker (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic authOk,
  input wire logic rxStart,
  input wire logic rxBitValid,
  input wire logic rxBitColl,
  input wire logic cipherActive,
  input wire logic byteOriented,
  input wire logic collisionDetected,
  input wire logic integrityError
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  logic take;
  logic wr;
  logic hit;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = take && wb_we_i && wb_sel_i[0];
  assign hit = rxBitValid && rxBitColl;
  property p_ack_next; take |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_cipher_set;
    $rose(cipherActive) |-> $past(authOk) || $past(authOk, 2);
  endproperty
  a_cipher_set: assert property (p_cipher_set)
    else $error("cipher set without auth");
  property p_cipher_clr;
    wr && wb_adr_i == 8'h0b && !wb_dat_i[5] && !authOk |-> ##2 !cipherActive;
  endproperty
  a_cipher_clr: assert property (p_cipher_clr)
    else $error("cipher not cleared");
  property p_orient;
    wr && wb_adr_i == 8'h0c
      |-> ##2 byteOriented == ($past(wb_dat_i[6:4], 2) == 3'h0);
  endproperty
  a_orient: assert property (p_orient)
    else $error("orientation wrong");
  property p_coll; $rose(collisionDetected) |-> $past(hit) || $past(hit, 2);
  endproperty
  a_coll: assert property (p_coll)
    else $error("collision flag without collision");
  property p_integ; $rose(integrityError) |-> $past(hit) || $past(hit, 2);
  endproperty
  a_integ: assert property (p_integ)
    else $error("integrity flag without collision");
  property p_clr;
    rxStart && !rxBitValid |=> !collisionDetected && !integrityError;
  endproperty
  a_clr: assert property (p_clr)
    else $error("flags not cleared at start");
endmodule : rxsc_checker
bind rxsc_regs rxsc_checker u_chk (.*);

// ### rxsc_card_model.sv
// card side model driving the receive decoder inputs
`timescale 1ns/100ps
module rxsc_card_model (
  input wire logic ref_clk,
  output rxsc_pkg::rxsc_link_state_t linkState,
  output logic authOk,
  output logic rxStart,
  output logic rxEnd,
  output logic rxBitValid,
  output logic rxBitData,
  output logic rxBitColl
);
  initial
  begin
    linkState = rxsc_pkg::RXSC_IDLE;
    {authOk, rxStart, rxEnd, rxBitValid, rxBitData, rxBitColl} = 6'h00;
  end
  // one cycle pulse on auth, start or end
  task automatic tick(input logic [2:0] p);
    @(posedge ref_clk);
    {authOk, rxStart, rxEnd} <= p;
    @(posedge ref_clk);
    {authOk, rxStart, rxEnd} <= 3'h0;
  endtask : tick
  task automatic state(input rxsc_pkg::rxsc_link_state_t s);
    @(posedge ref_clk);
    linkState <= s;
  endtask : state
  // data line shows the inverse of the last bit between bits
  task automatic bits(input logic [127:0] d, input int n, input int c);
    for (int i = 0; i < n; i++)
    begin
      @(posedge ref_clk);
      {rxBitValid, rxBitData, rxBitColl} <= {1'b1, d[i], i == c};
      @(posedge ref_clk);
      {rxBitValid, rxBitData, rxBitColl} <= {1'b0, ~d[i], 1'b0};
    end
  endtask : bits
endmodule : rxsc_card_model

// ### tb_top.sv
// self-checking testbench of the receive status and collision registers
`timescale 1ns/100ps
module tb_top;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  rxsc_pkg::rxsc_wb_req_t req = '0;
  rxsc_pkg::rxsc_link_state_t linkState;
  logic authOk, rxStart, rxEnd, rxBitValid, rxBitData, rxBitColl;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, cipherActive, byteOriented, storeValid, irq;
  logic collisionDetected, integrityError;
  logic [7:0] storeByte;
  logic [7:0] stored[$];
  int mismatches = 0;
  int nTests = 0;
  always #2.5 ref_clk = ~ref_clk;
  rxsc_card_model card (.*);
  rxsc_regs uut (.*, .wb_cyc_i(req.cyc), .wb_stb_i(req.stb), .wb_we_i(req.we),
    .wb_adr_i(req.adr), .wb_sel_i(req.sel), .wb_dat_i(req.dat));
  always @(posedge ref_clk)
    if (storeValid === 1'b1)
      stored.push_back(storeByte);
  task automatic complete_run;
    $display("tests %0d mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [7:0] e, g);
    nTests++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, d,
    output logic [7:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    req <= {1'b1, 1'b1, w, a, 4'hf, 24'h0, d};
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 64);
    if (n >= 64)
    begin
      mismatches++;
      complete_run();
    end
    q = wb_dat_o[7:0];
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input string nm, input logic [7:0] a, e, m);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(nm, e, q & m);
  endtask : rd
  task automatic t_regs;
    rxsc_pkg::rxsc_link_state_t s;
    s = s.first();
    repeat (6)
    begin
      card.state(s);
      rd("state", 8'h0b, {5'h00, s}, 8'hff);
      s = s.next();
    end
    wr(8'h0b, 8'hff);
    rd("status", 8'h0b, 8'h07, 8'hff);
    wr(8'h0c, 8'hff);
    rd("bitctrl", 8'h0c, 8'hf8, 8'hff);
    wr(8'h20, 8'hff);
    rd("unmapped", 8'h20, 8'h00, 8'hff);
    card.state(rxsc_pkg::rxsc_link_state_t'(3'h4));
    rd("unused state", 8'h0b, 8'h00, 8'hff);
    card.state(rxsc_pkg::RXSC_RX);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_cipher;
    card.tick(3'h4);
    rd("cipher on", 8'h0b, 8'h27, 8'hff);
    wr(8'h0b, 8'h00);
    rd("cipher off", 8'h0b, 8'h07, 8'hff);
    chk("cipher pin", 8'h00, {7'h00, cipherActive});
    $display("t_cipher done");
  endtask : t_cipher
  task automatic t_align7;
    wr(8'h0f, 8'h01);
    wr(8'h0c, 8'h78);
    stored.delete();
    card.tick(3'h2);
    card.bits(128'h3fb, 10, 2);
    card.tick(3'h1);
    chk("byte0", 8'h80, stored[0]);
    chk("byte1", 8'h01, stored[1]);
    rd("coll", 8'h0d, 8'h89, 8'hff);
    rd("last bits", 8'h0c, 8'h79, 8'hff);
    chk("integ", 8'h01, {7'h00, integrityError});
    rd("err flags", 8'h10, 8'h03, 8'hff);
    rd("irq mask", 8'h0f, 8'h01, 8'hff);
    rd("irq stat", 8'h0e, 8'h07, 8'hff);
    chk("irq on", 8'h01, {7'h00, irq});
    wr(8'h0e, 8'h01);
    @(negedge ref_clk);
    chk("irq off", 8'h00, {7'h00, irq});
    $display("t_align7 done");
  endtask : t_align7
  task automatic t_byte(input int c, input logic [7:0] e, m);
    wr(8'h0c, 8'h80);
    stored.delete();
    card.tick(3'h2);
    rd("start", 8'h0c, 8'h80, 8'hff);
    chk("orient", 8'h01, {7'h00, byteOriented});
    card.bits({64'h1, 64'ha5a5_a5a5_a5a5_a5a5}, 65, c);
    card.tick(3'h1);
    chk("byte", 8'ha5, stored[0]);
    chk("byte7", 8'ha5, stored[7]);
    rd("coll", 8'h0d, e, m);
    chk("coll det", 8'h01, {7'h00, collisionDetected});
    chk("no integ", 8'h00, {7'h00, integrityError});
    rd("err flags", 8'h10, 8'h02, 8'hff);
    $display("t_byte done");
  endtask : t_byte
  initial
  begin
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_regs();
    t_cipher();
    t_align7();
    t_byte(63, 8'hbf, 8'hff);
    t_byte(64, 8'h00, 8'h80);
    complete_run();
  end
endmodule : tb_top
